// ===== src/strap_cfg_pkg.sv
// Shared constants for the strap-pin configuration loader
package strap_cfg_pkg;

	// ----------------------------------------
	// Register and strap widths
	// ----------------------------------------
	localparam int REG_W = 8;
	localparam int STRAP_W = 8;
	localparam int SRC_W = 2;
	localparam int BOOST_W = 2;

	// ----------------------------------------
	// Packed strap bus layout (internal only)
	// ----------------------------------------
	localparam int SP_FAST_EN = 7;
	localparam int SP_SRC_HI = 6;
	localparam int SP_SRC_LO = 5;
	localparam int SP_EQ = 4;
	localparam int SP_BOOST_HI = 3;
	localparam int SP_BOOST_LO = 2;
	localparam int SP_OUT_TERM = 1;
	localparam int SP_DRIVE = 0;

	// ----------------------------------------
	// Field positions inside the registers
	// ----------------------------------------
	localparam int FAST_EN_BIT = 6;
	localparam int MODE_HI = 5;
	localparam int MODE_LO = 4;
	localparam int SRC_PAD_HI = 3;
	localparam int SRC_PAD_LO = 2;
	localparam int SRC_HI = 1;
	localparam int SRC_LO = 0;
	localparam int AUX_EN_BIT = 6;
	localparam int RX_TERM_BIT = 0;
	localparam int BOOST_HI = 3;
	localparam int BOOST_LO = 2;
	localparam int OUT_TERM_BIT = 1;
	localparam int DRIVE_BIT = 0;

	// ----------------------------------------
	// Fixed field values and reset values
	// ----------------------------------------
	localparam logic [1:0] MODE_QUAD = 2'h0;
	localparam logic [1:0] SRC_PAD = 2'h0;
	localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
	localparam logic [REG_W-1:0] FAST_MODE_RST = 8'h00;
	localparam logic [REG_W-1:0] AUX_MODE_RST = 8'h40;
	localparam logic [REG_W-1:0] IN_TERM_RST = 8'h01;

	// ----------------------------------------
	// Analog settings selected by the fields
	// ----------------------------------------
	localparam logic [4:0] DRIVE_LOW_MA = 5'h0a;
	localparam logic [4:0] DRIVE_HIGH_MA = 5'h14;
	localparam logic [3:0] EQ_LOW_DB = 4'h6;
	localparam logic [3:0] EQ_HIGH_DB = 4'hc;
	localparam logic [2:0] BOOST_STEP_DB = 3'h2;

	// ----------------------------------------
	// Loader states, one-hot
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_SETTLE = 3'h1,
		ST_STRAP = 3'h2,
		ST_SERIAL = 3'h4
	} loader_state_t;

endpackage

// ===== src/strap_sync.sv
// Two-flop synchroniser for the static strap pins
`timescale 1ns/1ps
`default_nettype none
module strap_sync
	import strap_cfg_pkg::*;
#(
	parameter int WIDTH = STRAP_W
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] meta;

	// Straps are static, but a board may still be settling at reset release
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				meta[i] <= 1'b0;
				synced[i] <= 1'b0;
			end else begin
				meta[i] <= pins[i];
				synced[i] <= meta[i];
			end
		end
	end

endmodule
`default_nettype wire

// ===== src/strap_decode.sv
// Turns register fields into the analog settings they select
`timescale 1ns/1ps
`default_nettype none
module strap_decode
	import strap_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic drive_bit,
	input wire logic eq_bit,
	input wire logic [BOOST_W-1:0] boost_field,
	output logic [4:0] drive_current_ma,
	output logic [3:0] eq_gain_db,
	output logic [2:0] boost_gain_db
);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_current_ma <= DRIVE_LOW_MA;
			eq_gain_db <= EQ_LOW_DB;
			boost_gain_db <= 3'h0;
		end else begin
			drive_current_ma <= drive_bit ? DRIVE_HIGH_MA : DRIVE_LOW_MA;
			eq_gain_db <= eq_bit ? EQ_HIGH_DB : EQ_LOW_DB;
			// Two dB per step: 0, 2, 4, 6
			boost_gain_db <= 3'(boost_field * BOOST_STEP_DB);
		end
	end

endmodule
`default_nettype wire

// ===== src/pin_strap_switch_config.sv
// Strap-pin configuration loader for the 4:1 signal switch
//
// How it works
// - Output current bit clear gives 10 mA, set gives 20 mA, all outputs.
// - Registers load straight from the eight dedicated strap pin levels.
// - Strap path honoured only after reset, before any serial register access.
// - Strap tied high reads as one, tied to ground as zero.
// - Under straps, high speed mode bits 5 and 4 read zero (quad).
// - Fast enable strap in bit 6: 0 standby, 1 channels on.
// - Source straps in bits 1:0, bits 3:2 zero, pick A, B, C or D.
// - Auxiliary switch always enabled, bit 6 one, mode bits 5:4 zero.
// - Same source straps drive auxiliary source select in bits 1:0.
// - Input termination bit 0 forced to one, termination always on.
// - Both termination pulse registers hold all eight bits zero.
// - Every bit of both equalizer registers copies the equalization strap.
// - Driver settings hold boost in 3:2, out term in 1, current in 0.
// - Pulsed termination disconnect on source change disabled for every input.
// - Equalization strap 0 gives 6 dB, 1 gives 12 dB, no per-channel.
// - Boost field 00,01,10,11 gives 0, 2, 4, 6 dB for all outputs.
`timescale 1ns/1ps
`default_nettype none
module pin_strap_switch_config
	import strap_cfg_pkg::*;
#(
	parameter int SETTLE_CYCLES = 2
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic strap_fast_enable,
	input wire logic [SRC_W-1:0] strap_source_sel,
	input wire logic strap_eq_level,
	input wire logic [BOOST_W-1:0] strap_boost_level,
	input wire logic strap_out_term,
	input wire logic strap_drive_current,
	input wire logic serial_access,
	output logic strap_active,
	output logic [REG_W-1:0] fast_path_mode_ctrl,
	output logic [REG_W-1:0] side_channel_mode_ctrl,
	output logic [REG_W-1:0] input_term_ctrl,
	output logic [REG_W-1:0] term_pulse_ab,
	output logic [REG_W-1:0] term_pulse_cd,
	output logic [REG_W-1:0] eq_level_ab,
	output logic [REG_W-1:0] eq_level_cd,
	output logic [REG_W-1:0] driver_settings,
	output logic fast_path_on,
	output logic [3:0] fast_source_onehot,
	output logic [3:0] side_source_onehot,
	output logic in_term_on,
	output logic out_term_on,
	output logic drive_current_sel,
	output logic [4:0] drive_current_ma,
	output logic [3:0] eq_gain_db,
	output logic [2:0] boost_gain_db
);

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	logic [STRAP_W-1:0] strap_pins;
	logic [STRAP_W-1:0] strap_now;

	// Pin level is taken as is: high is one, ground is zero
	assign strap_pins = {strap_fast_enable, strap_source_sel, strap_eq_level,
		strap_boost_level, strap_out_term, strap_drive_current};

	strap_sync #(
		.WIDTH(STRAP_W)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.pins(strap_pins),
		.synced(strap_now)
	);

	// ----------------------------------------
	// Loader state
	// ----------------------------------------
	localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);

	loader_state_t state;
	loader_state_t next_state;
	logic [3:0] settle_cnt;
	logic load_en;

	always_comb begin
		next_state = state;
		case (state)
			ST_SETTLE: begin
				if (serial_access) begin
					next_state = ST_SERIAL;
				end else if (settle_cnt == SETTLE_LAST) begin
					next_state = ST_STRAP;
				end
			end
			ST_STRAP: begin
				if (serial_access) begin
					next_state = ST_SERIAL;
				end
			end
			ST_SERIAL: begin
				// Only a reset reopens the strap path
				next_state = ST_SERIAL;
			end
			default: begin
				next_state = ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_SETTLE;
		end else begin
			state <= next_state;
		end
	end

	// Waits until the synchroniser holds real pin levels, not reset zeros
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			settle_cnt <= 4'h0;
		end else if (state == ST_SETTLE) begin
			settle_cnt <= settle_cnt + 4'h1;
		end
	end

	// An access in the same cycle already closes the path
	assign load_en = (state == ST_STRAP) && !serial_access;
	assign strap_active = (state != ST_SERIAL);

	// ----------------------------------------
	// Register images built from straps
	// ----------------------------------------
	logic [REG_W-1:0] next_fast_mode;
	logic [REG_W-1:0] next_aux_mode;
	logic [REG_W-1:0] next_driver;

	always_comb begin
		next_fast_mode = REG_ZERO;
		next_fast_mode[FAST_EN_BIT] = strap_now[SP_FAST_EN];
		next_fast_mode[MODE_HI:MODE_LO] = MODE_QUAD;
		next_fast_mode[SRC_PAD_HI:SRC_PAD_LO] = SRC_PAD;
		next_fast_mode[SRC_HI:SRC_LO] = strap_now[SP_SRC_HI:SP_SRC_LO];
	end

	always_comb begin
		next_aux_mode = REG_ZERO;
		next_aux_mode[AUX_EN_BIT] = 1'b1;
		next_aux_mode[MODE_HI:MODE_LO] = MODE_QUAD;
		next_aux_mode[SRC_PAD_HI:SRC_PAD_LO] = SRC_PAD;
		next_aux_mode[SRC_HI:SRC_LO] = strap_now[SP_SRC_HI:SP_SRC_LO];
	end

	always_comb begin
		next_driver = REG_ZERO;
		next_driver[BOOST_HI:BOOST_LO] = strap_now[SP_BOOST_HI:SP_BOOST_LO];
		next_driver[OUT_TERM_BIT] = strap_now[SP_OUT_TERM];
		next_driver[DRIVE_BIT] = strap_now[SP_DRIVE];
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_path_mode_ctrl <= FAST_MODE_RST;
		end else if (load_en) begin
			fast_path_mode_ctrl <= next_fast_mode;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			side_channel_mode_ctrl <= AUX_MODE_RST;
		end else if (load_en) begin
			side_channel_mode_ctrl <= next_aux_mode;
		end
	end

	// Fixed fields stay put; no pin can change them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			input_term_ctrl <= IN_TERM_RST;
			term_pulse_ab <= REG_ZERO;
			term_pulse_cd <= REG_ZERO;
		end else if (load_en) begin
			input_term_ctrl <= IN_TERM_RST;
			term_pulse_ab <= REG_ZERO;
			term_pulse_cd <= REG_ZERO;
		end
	end

	// One strap fans out to every input; per-channel levels are not reachable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eq_level_ab <= REG_ZERO;
			eq_level_cd <= REG_ZERO;
		end else if (load_en) begin
			eq_level_ab <= {REG_W{strap_now[SP_EQ]}};
			eq_level_cd <= {REG_W{strap_now[SP_EQ]}};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			driver_settings <= REG_ZERO;
		end else if (load_en) begin
			driver_settings <= next_driver;
		end
	end

	// ----------------------------------------
	// Controls driven into the switch fabric
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_path_on <= 1'b0;
			fast_source_onehot <= 4'h1;
			side_source_onehot <= 4'h1;
		end else begin
			fast_path_on <= fast_path_mode_ctrl[FAST_EN_BIT];
			fast_source_onehot <= 4'h1 << fast_path_mode_ctrl[SRC_HI:SRC_LO];
			side_source_onehot <= 4'h1 << side_channel_mode_ctrl[SRC_HI:SRC_LO];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_term_on <= 1'b1;
			out_term_on <= 1'b0;
			drive_current_sel <= 1'b0;
		end else begin
			// Pulsed disconnect is off, so termination simply follows this bit
			in_term_on <= input_term_ctrl[RX_TERM_BIT] && (term_pulse_ab == REG_ZERO)
				&& (term_pulse_cd == REG_ZERO);
			out_term_on <= driver_settings[OUT_TERM_BIT];
			drive_current_sel <= driver_settings[DRIVE_BIT];
		end
	end

	strap_decode u_decode (
		.clk(clk),
		.arst_n(arst_n),
		.drive_bit(driver_settings[DRIVE_BIT]),
		.eq_bit(eq_level_ab[0]),
		.boost_field(driver_settings[BOOST_HI:BOOST_LO]),
		.drive_current_ma(drive_current_ma),
		.eq_gain_db(eq_gain_db),
		.boost_gain_db(boost_gain_db)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Settle ends SETTLE_CYCLES edges after its first sampled cycle
	localparam int SETTLE_MAX = SETTLE_CYCLES;

	sequence s_strap_load;
		state == ST_STRAP && !serial_access;
	endsequence

	sequence s_closed;
		state == ST_SERIAL;
	endsequence

	property p_loads_pins;
		@(posedge clk) disable iff (!arst_n)
		s_strap_load |=> fast_path_mode_ctrl[FAST_EN_BIT] == $past(strap_now[SP_FAST_EN])
			&& driver_settings[DRIVE_BIT] == $past(strap_now[SP_DRIVE])
			&& eq_level_cd[7] == $past(strap_now[SP_EQ]);
	endproperty

	property p_frozen;
		@(posedge clk) disable iff (!arst_n)
		s_closed |=> s_closed ##0 ($stable(fast_path_mode_ctrl) && $stable(driver_settings)
			&& $stable(eq_level_ab) && $stable(side_channel_mode_ctrl));
	endproperty

	a_loads_pins: assert property (p_loads_pins) else $error("register missed strap value");
	a_frozen_closed: assert property (p_frozen) else $error("register moved after serial access");

	a_access_closes: assert property (@(posedge clk) disable iff (!arst_n)
		serial_access |=> !strap_active [*3]) else $error("strap path still open");

	a_settle_bound: assert property (@(posedge clk) disable iff (!arst_n)
		(state == ST_SETTLE) && !serial_access |-> ##[1:SETTLE_MAX] (state != ST_SETTLE))
		else $error("settle phase too long");

	a_quad_fixed: assert property (@(posedge clk) disable iff (!arst_n)
		fast_path_mode_ctrl[MODE_HI:SRC_PAD_LO] == 4'h0
		&& side_channel_mode_ctrl[MODE_HI:SRC_PAD_LO] == 4'h0)
		else $error("mode or pad bits not zero");

	a_aux_on: assert property (@(posedge clk) disable iff (!arst_n)
		side_channel_mode_ctrl[AUX_EN_BIT] && side_channel_mode_ctrl[7] == 1'b0)
		else $error("auxiliary switch not enabled");

	a_same_source: assert property (@(posedge clk) disable iff (!arst_n)
		s_strap_load ##1 1'b1 |=> side_source_onehot == fast_source_onehot
		&& fast_source_onehot == (4'h1 << $past(strap_now[SP_SRC_HI:SP_SRC_LO], 2)))
		else $error("source select mismatch");

	a_term_fixed: assert property (@(posedge clk) disable iff (!arst_n)
		input_term_ctrl == IN_TERM_RST && term_pulse_ab == REG_ZERO && term_pulse_cd == REG_ZERO
		|=> in_term_on) else $error("input termination not held on");

	a_eq_broadcast: assert property (@(posedge clk) disable iff (!arst_n)
		eq_level_ab == eq_level_cd && (eq_level_ab == REG_ZERO || eq_level_ab == 8'hff))
		else $error("equalizer bits differ");

	a_drive_ma: assert property (@(posedge clk) disable iff (!arst_n)
		$changed(driver_settings[DRIVE_BIT]) |=> drive_current_ma
		== ($past(driver_settings[DRIVE_BIT]) ? DRIVE_HIGH_MA : DRIVE_LOW_MA))
		else $error("drive current wrong");

	a_boost_db: assert property (@(posedge clk) disable iff (!arst_n)
		$changed(driver_settings[BOOST_HI:BOOST_LO]) |=> boost_gain_db
		== 3'($past(driver_settings[BOOST_HI:BOOST_LO]) * BOOST_STEP_DB))
		else $error("boost level wrong");

endmodule
`default_nettype wire

// ===== bench/strap_board.sv
// Board-level strap model: each pin is tied to a supply rail
`timescale 1ns/1ps
`default_nettype none
module strap_board (
	input wire logic [7:0] level,
	output logic strap_fast_enable,
	output logic [1:0] strap_source_sel,
	output logic strap_eq_level,
	output logic [1:0] strap_boost_level,
	output logic strap_out_term,
	output logic strap_drive_current
);
	// ----------------------------------------
	// Rail ties
	// ----------------------------------------
	// Straps are hard ties, so a pin is always driven to a clean 1 or 0, never left floating
	assign strap_fast_enable = level[7];
	assign strap_source_sel = level[6:5];
	assign strap_eq_level = level[4];
	assign strap_boost_level = level[3:2];
	assign strap_out_term = level[1];
	assign strap_drive_current = level[0];
endmodule
`default_nettype wire

// ===== bench/pin_strap_switch_config_tb.sv
// Self-checking bench for the strap-pin configuration loader
`timescale 1ns/1ps
`default_nettype none
module pin_strap_switch_config_tb;
	logic clk = 1'b0;
	logic arst_n;
	logic serial_access;
	logic [7:0] level;
	logic fe, eqp, ot, dc, strap_active, fast_path_on, in_term_on, out_term_on, drive_current_sel;
	logic [1:0] src, bst;
	logic [7:0] fast_path_mode_ctrl, side_channel_mode_ctrl, input_term_ctrl, term_pulse_ab, term_pulse_cd;
	logic [7:0] eq_level_ab, eq_level_cd, driver_settings;
	logic [3:0] fast_source_onehot, side_source_onehot, eq_gain_db;
	logic [4:0] drive_current_ma;
	logic [2:0] boost_gain_db;
	int num_errors;
	int compares;

	always #2.5 clk = ~clk;

	strap_board board (.level(level), .strap_fast_enable(fe), .strap_source_sel(src), .strap_eq_level(eqp),
		.strap_boost_level(bst), .strap_out_term(ot), .strap_drive_current(dc));

	pin_strap_switch_config #(.SETTLE_CYCLES(2)) DUT (.clk(clk), .arst_n(arst_n), .strap_fast_enable(fe),
		.strap_source_sel(src), .strap_eq_level(eqp), .strap_boost_level(bst), .strap_out_term(ot),
		.strap_drive_current(dc), .serial_access(serial_access), .strap_active(strap_active),
		.fast_path_mode_ctrl(fast_path_mode_ctrl), .side_channel_mode_ctrl(side_channel_mode_ctrl),
		.input_term_ctrl(input_term_ctrl), .term_pulse_ab(term_pulse_ab), .term_pulse_cd(term_pulse_cd),
		.eq_level_ab(eq_level_ab), .eq_level_cd(eq_level_cd), .driver_settings(driver_settings),
		.fast_path_on(fast_path_on), .fast_source_onehot(fast_source_onehot),
		.side_source_onehot(side_source_onehot), .in_term_on(in_term_on), .out_term_on(out_term_on),
		.drive_current_sel(drive_current_sel), .drive_current_ma(drive_current_ma),
		.eq_gain_db(eq_gain_db), .boost_gain_db(boost_gain_db));

	// ----------------------------------------
	// Shared comparison helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Expected register and decode values for a strap pattern {en, src[1:0], eq, boost[1:0], oterm, cur}
	task automatic check_all(input logic [7:0] s);
		chk(fast_path_mode_ctrl, {1'b0, s[7], 4'h0, s[6:5]}, "fast mode");
		chk(side_channel_mode_ctrl, {2'b01, 4'h0, s[6:5]}, "side mode");
		chk(input_term_ctrl, 8'h01, "input term");
		chk(term_pulse_ab, 8'h00, "pulse ab");
		chk(term_pulse_cd, 8'h00, "pulse cd");
		chk(eq_level_ab, {8{s[4]}}, "eq ab");
		chk(eq_level_cd, {8{s[4]}}, "eq cd");
		chk(driver_settings, {4'h0, s[3:0]}, "driver");
		chk({7'h00, fast_path_on}, {7'h00, s[7]}, "fast on");
		chk({4'h0, fast_source_onehot}, 8'h01 << s[6:5], "fast source");
		chk({4'h0, side_source_onehot}, 8'h01 << s[6:5], "side source");
		chk({7'h00, in_term_on}, 8'h01, "in term on");
		chk({7'h00, out_term_on}, {7'h00, s[1]}, "out term on");
		chk({7'h00, drive_current_sel}, {7'h00, s[0]}, "current sel");
		chk({3'h0, drive_current_ma}, s[0] ? 8'h14 : 8'h0a, "current ma");
		chk({4'h0, eq_gain_db}, s[4] ? 8'h0c : 8'h06, "eq db");
		chk({5'h00, boost_gain_db}, {5'h00, s[3:2], 1'b0}, "boost db");
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Straps are ignored while reset holds; release may coincide with a serial access
	task automatic do_reset(input logic [7:0] s, input logic access);
		level = s;
		arst_n = 1'b0;
		repeat (8) @(negedge clk);
		check_all(8'h00);
		chk({7'h00, strap_active}, 8'h01, "active in reset");
		arst_n = 1'b1;
		serial_access = access;
	endtask

	// Every source and boost code, both levels of every single-bit strap
	task automatic load_table();
		logic [7:0] pat [5];
		pat = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h3c};
		foreach (pat[i]) begin
			level = pat[i];
			repeat (6) @(negedge clk);
			check_all(pat[i]);
		end
	endtask

	// A pin change must pass the synchroniser: no load before the third edge
	task automatic load_latency();
		level = 8'h00;
		repeat (6) @(negedge clk);
		level = 8'hff;
		repeat (2) @(negedge clk);
		chk(fast_path_mode_ctrl, 8'h00, "early load");
		@(negedge clk);
		chk(fast_path_mode_ctrl, 8'h43, "load at third edge");
	endtask

	// After a serial access the registers freeze; a second access changes nothing
	task automatic freeze_after_access(input logic [7:0] p);
		level = p;
		repeat (6) @(negedge clk);
		// New levels leave the synchroniser one edge before the access edge, which must not load them
		level = ~p;
		repeat (2) @(negedge clk);
		serial_access = 1'b1;
		@(negedge clk);
		serial_access = 1'b0;
		chk({7'h00, strap_active}, 8'h00, "path closed");
		repeat (6) @(negedge clk);
		check_all(p);
		serial_access = 1'b1;
		@(negedge clk);
		serial_access = 1'b0;
		repeat (6) @(negedge clk);
		check_all(p);
	endtask

	// Access during settle closes the path before any load happens
	task automatic access_in_settle();
		do_reset(8'hff, 1'b1);
		@(negedge clk);
		serial_access = 1'b0;
		repeat (6) @(negedge clk);
		check_all(8'h00);
		chk({7'h00, strap_active}, 8'h00, "closed in settle");
	endtask

	// ----------------------------------------
	// Closing and sequencing
	// ----------------------------------------
	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		num_errors = 0;
		compares = 0;
		arst_n = 1'b0;
		serial_access = 1'b0;
		level = 8'h00;
		do_reset(8'hff, 1'b0);
		load_table();
		load_latency();
		freeze_after_access(8'ha5);
		access_in_settle();
		do_reset(8'h5a, 1'b0);
		repeat (6) @(negedge clk);
		check_all(8'h5a);
		end_of_test();
	end

	// Whole run is about 100 cycles; this limit leaves ample margin
	initial begin
		repeat (2000) @(negedge clk);
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
